//--- rtl/seq_pkg.sv
// Purpose: constants and types of the command sequence runner
// Assumes: 32-bit AXI4-Lite register port, 250 MHz clock
// Notes: table entry word = value[31:16] delay[15:8] func[7:5] next[4:0]
package seq_pkg;
  localparam int          CLK_HZ      = 250_000_000;
  localparam int          SECOND_S    = 1;
  localparam int          CYC_PER_SEC = CLK_HZ * SECOND_S;
  localparam int          N_CMD       = 20;
  localparam logic [11:0] A_CTRL      = 12'h000;
  localparam logic [11:0] A_LIST      = 12'h004;
  localparam logic [11:0] A_TGT_LOOPS = 12'h008;
  localparam logic [11:0] A_TGT_TIME  = 12'h00C;
  localparam logic [11:0] A_CMD_TMO   = 12'h010;
  localparam logic [11:0] A_SAVE_PER  = 12'h014;
  localparam logic [11:0] A_STATUS    = 12'h018;
  localparam logic [11:0] A_LOOP_CNT  = 12'h01C;
  localparam logic [11:0] A_LOOP_TIME = 12'h020;
  localparam logic [11:0] A_RUN_TIME  = 12'h024;
  localparam logic [11:0] A_TABLE     = 12'h080;
  localparam logic [11:0] CTRL_MASK   = 12'h3FF;
  // ctrl field positions
  localparam int C_EN = 0, C_RUN = 1, C_RES = 2, C_AUTO = 4, C_HALT = 6;
  localparam int C_TACT = 7, C_PERS = 8;
  // list field positions
  localparam int L_START = 0, L_LAST = 8, L_PFIRST = 16, L_PLAST = 24;
  localparam int L_PEN = 31;
  localparam logic [1:0] RES_PRE = 2'h0, RES_NOPRE = 2'h1, RES_CONT = 2'h2;
  localparam logic [1:0] AUTO_NO = 2'h0, AUTO_PRE = 2'h1;
  localparam logic [1:0] PERS_LOOPS = 2'h1, PERS_TIME = 2'h2;
  localparam logic [7:0] DLY_TARGET = 8'hFF;
  localparam logic [1:0] RESP_OK = 2'h0, RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_RUNNING, ST_STOPPING, ST_STOPPED,
                            ST_FINISHED, ST_TIMEOUT, ST_ERROR} seq_state_t;
  typedef enum logic [1:0] {PH_ISSUE, PH_BUSY, PH_DELAY} phase_t;
  typedef enum logic [2:0] {F_PARAM, F_OPEN, F_CLOSE, F_POSITION, F_PRESSURE,
                            F_LEARN, F_HOMING, F_DELAY} func_t;
endpackage : seq_pkg

//--- rtl/command_sequence_runner.sv
// Purpose: table-driven command sequencer with AXI4-Lite registers
// Assumes: cmd_done, cmd_fault, restart_req and nv_* come from clk logic
// Notes: cmd_valid and cmd_abort are one-cycle pulses
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module command_sequence_runner #(
  parameter int SEC_CYCLES = seq_pkg::CYC_PER_SEC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cmd_valid,
  output logic [2:0]       cmd_func,
  output logic [15:0]      cmd_value,
  output logic             cmd_abort,
  input  wire logic        cmd_done,
  input  wire logic        cmd_fault,
  input  wire logic        restart_req,
  input  wire logic [31:0] nv_loops,
  input  wire logic [31:0] nv_time,
  output logic             save_stb,
  output logic [31:0]      save_loops,
  output logic [31:0]      save_time
);
  import seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic [9:0]  ctrl_r;
  logic [31:0] list_r;
  logic [31:0] tgt_loops_r, tgt_time_r, cmd_tmo_r, save_per_r;
  logic [31:0] tbl [N_CMD];
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_got_r, w_got_r;
  seq_state_t  st_r;
  phase_t      ph_r;
  logic [4:0]  cur_r;
  logic        in_pre_r, run_q;
  logic [31:0] loop_cnt_r, loop_time_r, run_time_r;
  logic [31:0] wait_r, sec_cnt_r, save_cnt_r;
  logic [15:0] dly_r;
  logic        tick_r;

  // table slot hit and index
  function automatic logic tbl_hit(input logic [11:0] a);
    tbl_hit = a >= A_TABLE && a < A_TABLE + 12'(4 * N_CMD) && a[1:0] == 2'h0;
  endfunction : tbl_hit

  function automatic logic [4:0] tbl_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - A_TABLE;
    tbl_idx = d[6:2];
  endfunction : tbl_idx

  // byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    merge = r;
  endfunction : merge

  function automatic logic reg_hit(input logic [11:0] a, input logic wr);
    case (a)
      A_CTRL, A_LIST, A_TGT_LOOPS, A_TGT_TIME, A_CMD_TMO, A_SAVE_PER:
        reg_hit = 1'b1;
      A_STATUS, A_LOOP_CNT, A_LOOP_TIME, A_RUN_TIME: reg_hit = !wr;
      default: reg_hit = tbl_hit(a);
    endcase
  endfunction : reg_hit

  // field views
  logic       en, run, halt, tmo_stop;
  logic [1:0] res_pol, auto_mode, pers;
  logic [4:0] start_idx, loop_last, pre_first, pre_last;
  logic       pre_en;
  assign en        = ctrl_r[C_EN];
  assign run       = ctrl_r[C_RUN];
  assign res_pol   = ctrl_r[C_RES +: 2];
  assign auto_mode = ctrl_r[C_AUTO +: 2];
  assign halt      = ctrl_r[C_HALT];
  assign tmo_stop  = ctrl_r[C_TACT];
  assign pers      = ctrl_r[C_PERS +: 2];
  assign start_idx = list_r[L_START +: 5];
  assign loop_last = list_r[L_LAST +: 5];
  assign pre_first = list_r[L_PFIRST +: 5];
  assign pre_last  = list_r[L_PLAST +: 5];
  assign pre_en    = list_r[L_PEN];

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic wr_go;
  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_got_r      <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_got_r      <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_hit(awaddr_q, 1'b1) ? RESP_OK : RESP_SLVERR;
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // config register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r      <= 10'h000;
      list_r      <= 32'h0000_0000;
      tgt_loops_r <= 32'h0000_0000;
      tgt_time_r  <= 32'h0000_0000;
      cmd_tmo_r   <= 32'h0000_0000;
      save_per_r  <= 32'h0000_0000;
    end else if (wr_go) begin
      case (awaddr_q)
        A_CTRL: ctrl_r <= 10'(merge(32'(ctrl_r), wdata_q, wstrb_q));
        A_LIST:      list_r      <= merge(list_r, wdata_q, wstrb_q);
        A_TGT_LOOPS: tgt_loops_r <= merge(tgt_loops_r, wdata_q, wstrb_q);
        A_TGT_TIME:  tgt_time_r  <= merge(tgt_time_r, wdata_q, wstrb_q);
        A_CMD_TMO:   cmd_tmo_r   <= merge(cmd_tmo_r, wdata_q, wstrb_q);
        A_SAVE_PER:  save_per_r  <= merge(save_per_r, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // command table, twenty words
  always_ff @(posedge clk) begin
    if (wr_go && tbl_hit(awaddr_q)) begin
      tbl[tbl_idx(awaddr_q)] <= merge(tbl[tbl_idx(awaddr_q)], wdata_q,
                                      wstrb_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= reg_hit(s_axi_araddr, 1'b0) ? RESP_OK : RESP_SLVERR;
      case (s_axi_araddr)
        A_CTRL:      s_axi_rdata <= {22'h000000, ctrl_r};
        A_LIST:      s_axi_rdata <= list_r;
        A_TGT_LOOPS: s_axi_rdata <= tgt_loops_r;
        A_TGT_TIME:  s_axi_rdata <= tgt_time_r;
        A_CMD_TMO:   s_axi_rdata <= cmd_tmo_r;
        A_SAVE_PER:  s_axi_rdata <= save_per_r;
        A_STATUS:    s_axi_rdata <= {19'h0, cur_r, 5'h0, st_r};
        A_LOOP_CNT:  s_axi_rdata <= loop_cnt_r;
        A_LOOP_TIME: s_axi_rdata <= loop_time_r;
        A_RUN_TIME:  s_axi_rdata <= run_time_r;
        default: begin
          s_axi_rdata <= tbl_hit(s_axi_araddr) ?
                         tbl[tbl_idx(s_axi_araddr)] : 32'h0000_0000;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // current entry decode and successor choice
  logic [31:0] ent;
  logic [2:0]  e_func;
  logic [4:0]  e_next;
  logic [7:0]  e_dly;
  logic [15:0] e_val;
  logic [4:0]  adv_idx;
  logic        adv_pre, adv_wrap, run_rise, start_go, start_pre, keep_pos;
  logic        adv_now, fin_now, tmo_hit, done_ok;
  assign ent    = tbl[cur_r];
  assign e_func = ent[7:5];
  assign e_next = ent[4:0];
  assign e_dly  = ent[15:8];
  assign e_val  = ent[31:16];
  assign run_rise = run && !run_q;
  assign tmo_hit = tick_r && cmd_tmo_r != 32'h0000_0000 &&
                   wait_r + 32'h0000_0001 >= cmd_tmo_r;
  assign done_ok = (e_dly != DLY_TARGET) || cmd_done;

  always_comb begin
    adv_idx  = e_next;
    adv_pre  = in_pre_r;
    adv_wrap = 1'b0;
    if (in_pre_r && cur_r == pre_last) begin
      adv_idx = start_idx;
      adv_pre = 1'b0;
    end else if (!in_pre_r && cur_r == loop_last) begin
      adv_idx  = start_idx;
      adv_wrap = 1'b1;
    end
  end

  // advance, start and finish decisions
  always_comb begin
    adv_now = 1'b0;
    if (st_r == ST_RUNNING && en && run) begin
      case (ph_r)
        PH_BUSY: begin
          adv_now = (cmd_fault && !halt) ||
                    (!cmd_fault && done_ok && e_dly[7] &&
                     e_func != F_DELAY) ||
                    (!cmd_fault && !done_ok && tmo_hit && !tmo_stop);
        end
        PH_DELAY: adv_now = dly_r == 16'h0000;
        default:  adv_now = 1'b0;
      endcase
    end
    fin_now = adv_now && adv_wrap && tgt_loops_r != 32'h0000_0000 &&
              loop_cnt_r + 32'h0000_0001 == tgt_loops_r;
    start_go  = 1'b0;
    start_pre = 1'b1;
    keep_pos  = 1'b0;
    case (st_r)
      ST_IDLE, ST_FINISHED, ST_TIMEOUT, ST_ERROR: begin
        start_go = run_rise && en;
      end
      ST_STOPPED: begin
        start_go  = run_rise && en;
        start_pre = res_pol == RES_PRE;
        keep_pos  = res_pol == RES_CONT;
      end
      default: start_go = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r      <= ST_IDLE;
      ph_r      <= PH_ISSUE;
      cur_r     <= 5'h00;
      in_pre_r  <= 1'b0;
      run_q     <= 1'b0;
      wait_r    <= 32'h0000_0000;
      dly_r     <= 16'h0000;
      cmd_valid <= 1'b0;
      cmd_abort <= 1'b0;
      cmd_func  <= 3'h0;
      cmd_value <= 16'h0000;
    end else begin
      run_q     <= run;
      cmd_valid <= 1'b0;
      cmd_abort <= 1'b0;
      if (restart_req) begin
        st_r <= ST_IDLE;
        ph_r <= PH_ISSUE;
        if (auto_mode != AUTO_NO && en) begin
          st_r     <= ST_RUNNING;
          in_pre_r <= auto_mode == AUTO_PRE && pre_en;
          cur_r    <= (auto_mode == AUTO_PRE && pre_en) ? pre_first : start_idx;
        end
      end else if (start_go) begin
        st_r <= ST_RUNNING;
        ph_r <= PH_ISSUE;
        if (keep_pos) begin
          cur_r    <= adv_idx;
          in_pre_r <= adv_pre;
        end else begin
          in_pre_r <= start_pre && pre_en;
          cur_r    <= (start_pre && pre_en) ? pre_first : start_idx;
        end
      end else begin
        case (st_r)
          ST_RUNNING: begin
            if (!en || !run) begin
              st_r      <= ST_STOPPING;
              cmd_abort <= ph_r == PH_BUSY;
            end else if (tgt_time_r != 32'h0000_0000 &&
                         run_time_r >= tgt_time_r) begin
              st_r <= ST_FINISHED;
            end else if (adv_now) begin
              ph_r     <= PH_ISSUE;
              cur_r    <= adv_idx;
              in_pre_r <= adv_pre;
              if (fin_now) st_r <= ST_FINISHED;
              cmd_abort <= ph_r == PH_BUSY && !cmd_fault && !done_ok;
            end else begin
              case (ph_r)
                PH_ISSUE: begin
                  cmd_valid <= 1'b1;
                  cmd_func  <= e_func;
                  cmd_value <= e_val;
                  wait_r    <= 32'h0000_0000;
                  ph_r      <= PH_BUSY;
                end
                PH_BUSY: begin
                  if (tick_r) wait_r <= wait_r + 32'h0000_0001;
                  if (cmd_fault) begin
                    st_r <= ST_ERROR;
                  end else if (done_ok) begin
                    ph_r  <= PH_DELAY;
                    dly_r <= (e_func == F_DELAY) ? e_val : {8'h00, e_dly};
                  end else if (tmo_hit) begin
                    st_r      <= ST_TIMEOUT;
                    cmd_abort <= 1'b1;
                  end
                end
                PH_DELAY: begin
                  if (tick_r) dly_r <= dly_r - 16'h0001;
                end
                default: ph_r <= PH_ISSUE;
              endcase
            end
          end
          ST_STOPPING: st_r <= ST_STOPPED;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // second tick and progress counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_cnt_r <= 32'h0000_0000;
      tick_r    <= 1'b0;
    end else begin
      tick_r    <= sec_cnt_r == 32'(SEC_CYCLES - 1);
      sec_cnt_r <= (sec_cnt_r == 32'(SEC_CYCLES - 1)) ? 32'h0000_0000 :
                   sec_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_cnt_r  <= 32'h0000_0000;
      loop_time_r <= 32'h0000_0000;
      run_time_r  <= 32'h0000_0000;
    end else if (restart_req) begin
      loop_cnt_r  <= (pers == PERS_LOOPS) ? nv_loops : 32'h0000_0000;
      run_time_r  <= (pers == PERS_TIME) ? nv_time : 32'h0000_0000;
      loop_time_r <= 32'h0000_0000;
    end else if (start_go && !keep_pos) begin
      loop_cnt_r  <= 32'h0000_0000;
      loop_time_r <= 32'h0000_0000;
      run_time_r  <= 32'h0000_0000;
    end else begin
      if (adv_now && adv_wrap) begin
        loop_cnt_r  <= loop_cnt_r + 32'h0000_0001;
        loop_time_r <= 32'h0000_0000;
      end else if (tick_r && st_r == ST_RUNNING) begin
        loop_time_r <= loop_time_r + 32'h0000_0001;
      end
      if (tick_r && st_r == ST_RUNNING) begin
        run_time_r <= run_time_r + 32'h0000_0001;
      end
    end
  end

  // periodic saving of progress
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      save_stb   <= 1'b0;
      save_loops <= 32'h0000_0000;
      save_time  <= 32'h0000_0000;
      save_cnt_r <= 32'h0000_0000;
    end else begin
      save_stb   <= 1'b0;
      save_loops <= loop_cnt_r;
      save_time  <= run_time_r;
      if (pers == PERS_LOOPS && adv_now && adv_wrap) begin
        save_stb   <= 1'b1;
        save_loops <= loop_cnt_r + 32'h0000_0001;
      end
      if (pers == PERS_TIME && tick_r && st_r == ST_RUNNING) begin
        if (save_cnt_r + 32'h0000_0001 >= save_per_r) begin
          save_stb   <= 1'b1;
          save_time  <= run_time_r + 32'h0000_0001;
          save_cnt_r <= 32'h0000_0000;
        end else begin
          save_cnt_r <= save_cnt_r + 32'h0000_0001;
        end
      end
    end
  end
endmodule : command_sequence_runner
`default_nettype wire

//--- testbench/seq_runner_props.sv
// Purpose: port assertions for the command sequence runner
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every runner instance
`timescale 1ns/1ns
`default_nettype none
module seq_runner_props #(
  parameter int SEC_CYCLES = 10
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_func,
  input wire logic [15:0] cmd_value,
  input wire logic        cmd_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // write halves taken together, then the answer
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_soon;
    ##[1:3] s_axi_bvalid;
  endsequence
  write_answer_a: assert property (both_taken |-> resp_soon)
    else $error("write response missing");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid) else $error("read data missing");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  write_refuse_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read not refused");
  ////////////////////////////////////////////////////////////////////////////
  // command port pulses and held payload
  issue_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("issue pulse too long");
  abort_pulse_a: assert property (cmd_abort |=> !cmd_abort)
    else $error("abort pulse too long");
  entry_hold_a: assert property ($past(rst_n) && !cmd_valid
    |-> $stable(cmd_func) && $stable(cmd_value))
    else $error("entry payload moved");
endmodule : seq_runner_props
`default_nettype wire
bind command_sequence_runner seq_runner_props #(
  .SEC_CYCLES(SEC_CYCLES)
) seq_runner_props_i (
  .clk(clk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cmd_valid(cmd_valid),
  .cmd_func(cmd_func), .cmd_value(cmd_value), .cmd_abort(cmd_abort)
);

//--- testbench/command_sequence_runner_bench.sv
// Purpose: self-checking bench of the command sequence runner
// Assumes: ten cycles per second, xorshift stimulus from seed 75
// Notes: one restart pulse reloads a saved loop count; saved time stays 0
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module command_sequence_runner_bench;
  import seq_pkg::*;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, cmd_valid;
  logic        cmd_abort, cmd_done, cmd_fault, restart_req, save_stb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, nv_loops, nv_time, save_loops, save_time;
  logic [31:0] d, seed, sl;
  logic [31:0] tbl [N_CMD];
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, lresp;
  logic [2:0]  cmd_func, lf;
  logic [15:0] cmd_value, lv;
  logic [4:0]  s;
  int          mismatches, checked, issues, want, aborts;

  command_sequence_runner #(.SEC_CYCLES(10)) command_sequence_runner_i (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_valid(cmd_valid),
    .cmd_func(cmd_func), .cmd_value(cmd_value), .cmd_abort(cmd_abort),
    .cmd_done(cmd_done), .cmd_fault(cmd_fault), .restart_req(restart_req),
    .nv_loops(nv_loops), .nv_time(nv_time), .save_stb(save_stb),
    .save_loops(save_loops), .save_time(save_time));
  ////////////////////////////////////////////////////////////////////////////
  // clock and a log of issued entries and aborts
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      issues++;
      lf = cmd_func;
      lv = cmd_value;
    end
    if (cmd_abort === 1'b1) aborts++;
    if (save_stb === 1'b1) sl = save_loops;
  end
  ////////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic hung;
    mismatches++;
    wrap_up();
  endtask : hung
  ////////////////////////////////////////////////////////////////////////////
  // bus cycles: hold each channel until its own handshake
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) hung();
    lresp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) hung();
    v = rdata;
    lresp = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic state_is(input seq_state_t e);
    rd(A_STATUS, d);
    `CHK(d[2:0], e)
  endtask : state_is
  // wait for the next issued entry and compare it with the table
  task automatic wait_cmd(input logic [4:0] i);
    int n;
    want++;
    for (n = 0; n < 200 && issues < want; n++) @(posedge clk);
    if (n == 200) hung();
    `CHK(lf, tbl[i][7:5])
    `CHK(lv, tbl[i][31:16])
  endtask : wait_cmd
  task automatic pulse(input bit fault);
    @(posedge clk);
    if (fault) cmd_fault <= 1'b1;
    else cmd_done <= 1'b1;
    @(posedge clk);
    cmd_fault <= 1'b0;
    cmd_done <= 1'b0;
  endtask : pulse
  task automatic start(input logic [31:0] c);
    wr(A_CTRL, c & 32'hFFFFFFFD);
    wr(A_CTRL, c);
  endtask : start
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {clk, rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {cmd_done, cmd_fault, restart_req, awaddr, araddr, wdata} = '0;
    {nv_loops, nv_time} = '0;
    wstrb = 4'hF;
    seed = 32'h4B;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    state_is(ST_IDLE);
    rd(12'h040, d);
    `CHK({lresp, d}, {RESP_SLVERR, 32'h0})
    wr(A_STATUS, 32'h3);
    `CHK(lresp, RESP_SLVERR)
    // random table, every function, successor is the following entry
    for (int i = 0; i < N_CMD; i++) begin
      seed = xs(seed);
      tbl[i] = {seed[15:0], DLY_TARGET, 3'(i % 8), 5'((i + 1) % N_CMD)};
      wr(A_TABLE + 12'(4 * i), tbl[i]);
    end
    rd(A_TABLE + 12'h04C, d);
    `CHK(d, tbl[19])
    s = 5'(seed % 6) + (seed[7] ? 5'h8 : 5'h0);
    wr(A_LIST, {19'h0, 5'(s + 1), 3'h0, s});
    wr(A_TGT_LOOPS, 32'h1);
    wr(A_CTRL, 32'h2);
    repeat (8) @(posedge clk);
    `CHK(issues, 0)
    start(32'h3);
    wait_cmd(s);
    rd(A_STATUS, d);
    `CHK(d[12:8], s)
    pulse(1'b0);
    wait_cmd(s + 1);
    pulse(1'b0);
    state_is(ST_FINISHED);
    rd(A_LOOP_CNT, d);
    `CHK(d, 32'h1)
    start(32'h43);
    wait_cmd(s);
    pulse(1'b1);
    state_is(ST_ERROR);
    wr(A_CMD_TMO, 32'h1);
    start(32'h83);
    wait_cmd(s);
    for (int n = 0; n < 100 && aborts == 0; n++) @(posedge clk);
    `CHK(aborts, 1)
    state_is(ST_TIMEOUT);
    wr(A_CMD_TMO, 32'h0);
    start(32'h3);
    wait_cmd(s);
    wr(A_CTRL, 32'h1);
    state_is(ST_STOPPED);
    start(32'hB);
    wait_cmd(s + 1);
    // restart with autorun: preamble entry 16, saved loop count reloaded
    wr(A_LIST, {8'h90, 3'h0, 5'h10, 3'h0, 5'(s + 1), 3'h0, s});
    wr(A_TGT_LOOPS, (seed & 32'hFF) + 32'h1);
    wr(A_CTRL, 32'h113);
    nv_loops <= seed & 32'hFF;
    restart_req <= 1'b1;
    @(posedge clk);
    restart_req <= 1'b0;
    wait_cmd(5'h10);
    pulse(1'b1);
    wait_cmd(s);
    pulse(1'b0);
    wait_cmd(s + 1);
    pulse(1'b0);
    state_is(ST_FINISHED);
    `CHK(sl, (seed & 32'hFF) + 32'h1)
    rd(A_LOOP_CNT, d);
    `CHK(d, (seed & 32'hFF) + 32'h1)
    // time goal ends a run whose command never completes
    wr(A_TGT_LOOPS, 32'h0);
    wr(A_TGT_TIME, 32'h2);
    start(32'h3);
    repeat (40) @(posedge clk);
    state_is(ST_FINISHED);
    rd(A_RUN_TIME, d);
    `CHK(d, 32'h2)
    rd(A_LOOP_TIME, d);
    `CHK(d, 32'h2)
    wrap_up();
  end
endmodule : command_sequence_runner_bench
`default_nettype wire
